// file: dv/mtrb_host.sv
// Host model: one byte read per call; the answer is taken a cycle and a half after the read edge.
// Assumes the answer stands for one full cycle, so it is taken in the middle of it.
`timescale 1ns/1ns
module mtrb_host (
  // Clock
  input  wire       sys_clk,
  // Register access
  input  wire       reg_rvalid,
  input  wire [7:0] reg_rdata,
  output reg        reg_read = 1'b0,
  output reg  [7:0] reg_addr = 8'h00
);
  // Test reads only; navigation data would come through the HID reports
  task rd(input [7:0] a, output [8:0] d);
    @(posedge sys_clk);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_read <= 1'b0;
    reg_addr <= ~a;
    @(negedge sys_clk) d = {reg_rvalid, reg_rdata};
  endtask
endmodule

// file: dv/mtrb_monitor.sv
// Assertions on the bank read port; bound to the bank below, sees its ports only.
// Assumes a synchronous active-low reset and reads taken on the rising edge of sys_clk.
`timescale 1ns/1ns
module mtrb_monitor (
  // Clock and reset
  input wire       sys_clk,
  input wire       rst_b,
  // USB register access
  input wire       usb_reset,
  input wire       reg_read,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_rdata,
  input wire       reg_rvalid
);

  // Shadow of the X-low read flag, rebuilt from the port traffic
  reg        xr_reg;
  wire       rd;
  wire [8:0] rq;

  assign rd = reg_read & ~usb_reset;
  assign rq = {rd, reg_addr};

  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  always @(posedge sys_clk) begin
    xr_reg <= rst_b & ~usb_reset & (xr_reg | (rq == 9'h103));
  end

  property p_ack;
    rd |=> reg_rvalid;
  endproperty
  a_ack: assert property (p_ack) else $error("read not answered");

  property p_idle;
    !rd |=> !reg_rvalid && reg_rdata == 8'h00;
  endproperty
  a_idle: assert property (p_idle) else $error("answer without read");

  property p_usb;
    usb_reset |=> !reg_rvalid;
  endproperty
  a_usb: assert property (p_usb) else $error("read answered in usb reset");

  property p_rsv;
    rq == 9'h102 |=> reg_rdata[7:3] == 5'h00;
  endproperty
  a_rsv: assert property (p_rsv) else $error("reserved button bits set");

  property p_ord;
    rq[8:1] == 8'h82 && !xr_reg |=> reg_rdata == 8'h00;
  endproperty
  a_ord: assert property (p_ord) else $error("motion read out of order not zero");

  property p_whl;
    rq == 9'h106 |=> reg_rdata != 8'h80;
  endproperty
  a_whl: assert property (p_whl) else $error("wheel out of range");

  property p_sq;
    rq == 9'h107 |=> reg_rdata <= 8'h80;
  endproperty
  a_sq: assert property (p_sq) else $error("quality out of range");

  property p_rst;
    $rose(rst_b) |-> reg_rdata == 8'h00 && !reg_rvalid;
  endproperty
  a_rst: assert property (p_rst) else $error("outputs not cleared by reset");

endmodule

bind mtrb_register_bank mtrb_monitor mtrb_monitor_i (
  .sys_clk    (sys_clk),
  .rst_b      (rst_b),
  .usb_reset  (usb_reset),
  .reg_read   (reg_read),
  .reg_addr   (reg_addr),
  .reg_rdata  (reg_rdata),
  .reg_rvalid (reg_rvalid)
);

// file: dv/tb.sv
// Bench of the register bank; the host model issues every read.
// Assumes a 40 ns clock and reads answered one cycle after the strobe edge.
`timescale 1ns/1ns
module tb;
  reg        sys_clk = 0, rst_b = 0, usb_reset = 0, motion_load = 0, wheel_load = 0, frame_done = 0;
  reg [2:0]  button_raw = 0;
  reg [7:0]  wheel_in = 0, quality_in = 0;
  reg [11:0] motion_x = 0, motion_y = 0;
  reg [15:0] exposure_in = 0;
  wire       reg_read, reg_rvalid;
  wire [7:0] reg_addr, reg_rdata;
  integer    err_count = 0, checks = 0, i;
  mtrb_register_bank mtrb_register_bank_i (
    .sys_clk     (sys_clk),
    .rst_b       (rst_b),
    .usb_reset   (usb_reset),
    .reg_read    (reg_read),
    .reg_addr    (reg_addr),
    .reg_rdata   (reg_rdata),
    .reg_rvalid  (reg_rvalid),
    .button_raw  (button_raw),
    .motion_load (motion_load),
    .motion_x    (motion_x),
    .motion_y    (motion_y),
    .wheel_load  (wheel_load),
    .wheel_in    (wheel_in),
    .frame_done  (frame_done),
    .quality_in  (quality_in),
    .exposure_in (exposure_in)
  );
  mtrb_host mtrb_host_i (
    .sys_clk    (sys_clk),
    .reg_rvalid (reg_rvalid),
    .reg_rdata  (reg_rdata),
    .reg_read   (reg_read),
    .reg_addr   (reg_addr)
  );
  initial forever #20 sys_clk = ~sys_clk;
  task check(input [8:0] seen, input [8:0] expected);
    checks = checks + 1;
    if (seen !== expected) begin
      err_count = err_count + 1;
      $display("ERROR %0t read %h expected %h", $time, seen, expected);
    end
  endtask
  task chk(input [7:0] a, input [8:0] e);
    reg [8:0] g;
    mtrb_host_i.rd(a, g);
    check(g, e);
  endtask
  task t_reset;
    for (i = 3; i < 10; i = i + 1) chk(i[7:0], i == 9 ? 9'h164 : 9'h100);
    @(posedge sys_clk) usb_reset <= 1'b1;
    chk(8'h03, 9'h000);
    @(posedge sys_clk) usb_reset <= 1'b0;
  endtask
  task t_order;
    @(posedge sys_clk) {motion_load, motion_x, motion_y, button_raw} <= {1'b1, 24'ha5c3b7, 3'h5};
    @(posedge sys_clk) motion_load <= 1'b0;
    chk(8'h05, 9'h100);
    chk(8'h04, 9'h100);
    chk(8'h03, 9'h15c);
    chk(8'h04, 9'h1b7);
    chk(8'h05, 9'h1a3);
  endtask
  task t_misc;
    @(posedge sys_clk) {wheel_load, frame_done, wheel_in, quality_in, exposure_in} <= 34'h3_80ff_1234;
    @(posedge sys_clk) {wheel_load, frame_done, exposure_in} <= 18'h0_5678;
    chk(8'h06, 9'h181);
    chk(8'h07, 9'h180);
    chk(8'h08, 9'h112);
    @(posedge sys_clk) {frame_done, button_raw} <= 4'ha;
    chk(8'h09, 9'h134);
    chk(8'h02, 9'h105);
    @(posedge sys_clk) frame_done <= 1'b0;
    repeat (16) @(posedge sys_clk);
    chk(8'h02, 9'h102);
    chk(8'h08, 9'h156);
    chk(8'h09, 9'h178);
  endtask
  task t_rerun;
    @(posedge sys_clk) rst_b <= 1'b0;
    repeat (3) @(posedge sys_clk);
    rst_b <= 1'b1;
    chk(8'h05, 9'h100);
    chk(8'h09, 9'h164);
    chk(8'h02, 9'h100);
  endtask
  task end_of_test;
    $display("errors %0d checks %0d", err_count, checks);
    if (err_count == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge sys_clk);
    rst_b <= 1'b1;
    t_reset;
    t_order;
    t_misc;
    t_rerun;
    end_of_test;
  end
  initial #20000 begin
    err_count = err_count + 1;
    end_of_test;
  end
endmodule

// file: inc/mtrb_defs.vh
// Register map, value limits and reset values of the motion test register bank.
// Included by the register bank design file; holds definitions only.
`ifndef MTRB_DEFS_VH
`define MTRB_DEFS_VH

`define MTRB_ADDR_W          8
`define MTRB_OFF_BUTTON      8'h02
`define MTRB_OFF_X_LOW       8'h03
`define MTRB_OFF_Y_LOW       8'h04
`define MTRB_OFF_XY_HIGH     8'h05
`define MTRB_OFF_WHEEL       8'h06
`define MTRB_OFF_QUALITY     8'h07
`define MTRB_OFF_EXP_HIGH    8'h08
`define MTRB_OFF_EXP_LOW     8'h09

`define MTRB_RST_MOTION      12'h000
`define MTRB_RST_BYTE        8'h00
`define MTRB_RST_EXPOSURE    16'h0064
`define MTRB_RST_EXP_LOW     8'h64
`define MTRB_DEBOUNCE_CYCLES 16
`define MTRB_WHEEL_MAX       8'h7f
`define MTRB_WHEEL_MIN       8'h81
`define MTRB_QUALITY_MAX     8'h80
`define MTRB_UNMAPPED_DATA   8'h00

`endif

// file: logic/mtrb_button_filter.v
// Debounce filter for one button input.
// Assumes the raw level is already synchronous to sys_clk.
`timescale 1ns/1ns
module mtrb_button_filter #(
  parameter STABLE_CYCLES = 16
) (
  // Clock and reset
  input  wire sys_clk,
  input  wire rst_b,
  // Button
  input  wire raw_level,
  output reg  clean_level
);

  reg  [4:0]  stable_count_reg;
  wire [31:0] last_count;

  // Last count before a changed level is accepted
  assign last_count = STABLE_CYCLES - 1;

  always @(posedge sys_clk) begin
    if (!rst_b) begin
      stable_count_reg <= 5'h00;
      clean_level      <= 1'b0;
    end else if (raw_level == clean_level) begin
      stable_count_reg <= 5'h00;
    end else if (stable_count_reg == last_count[4:0]) begin
      stable_count_reg <= 5'h00;
      clean_level      <= raw_level;
    end else begin
      stable_count_reg <= stable_count_reg + 5'h01;
    end
  end

endmodule

// file: logic/mtrb_register_bank.v
// Read-only test register bank: buttons, motion, wheel, surface quality, exposure time.
// Assumes the USB function side presents byte reads as a one-cycle strobe with an address
// and that the sensing core delivers its values synchronous to sys_clk.
//
// Function
// - Buttons three, two, one in bits 2..0
// - Button bits come from debounced signals
// - X-low holds low byte of X motion
// - Y-low holds low byte of Y motion
// - XY-high holds X[11:8] upper, Y[11:8] lower
// - Motion values are two's-complement, resolution scaled
// - Y-low/XY-high without X-low read return zero
// - Wheel count clamped to -127..127
// - Surface quality never above 128
// - Exposure high/low form 16-bit clock count
// - Reset values zero, exposure low 0x64
// - USB reset or power loss disables access
`timescale 1ns/1ns
`include "mtrb_defs.vh"
module mtrb_register_bank (
  // Clock and reset
  input  wire        sys_clk,
  input  wire        rst_b,
  // USB register access
  input  wire        usb_reset,
  input  wire        reg_read,
  input  wire [7:0]  reg_addr,
  output reg  [7:0]  reg_rdata,
  output reg         reg_rvalid,
  // Sensing core
  input  wire [2:0]  button_raw,
  input  wire        motion_load,
  input  wire [11:0] motion_x,
  input  wire [11:0] motion_y,
  input  wire        wheel_load,
  input  wire [7:0]  wheel_in,
  input  wire        frame_done,
  input  wire [7:0]  quality_in,
  input  wire [15:0] exposure_in
);

  ////////////////////////////////////////////////////////////////////////
  // Debounced buttons

  wire [2:0] button_clean;

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_btn
      mtrb_button_filter #(
        .STABLE_CYCLES (`MTRB_DEBOUNCE_CYCLES)
      ) u_filter (
        .sys_clk     (sys_clk),
        .rst_b       (rst_b),
        .raw_level   (button_raw[gi]),
        .clean_level (button_clean[gi])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // Captured values

  reg [11:0] motion_x_reg;
  reg [11:0] motion_y_reg;
  reg [7:0]  wheel_reg;
  reg [7:0]  quality_reg;
  reg [15:0] exposure_reg;
  reg [7:0]  exp_low_latch_reg;
  reg        x_read_reg;

  reg [11:0] motion_x_next;
  reg [11:0] motion_y_next;
  reg [7:0]  wheel_next;
  reg [7:0]  quality_next;
  reg [15:0] exposure_next;
  reg [7:0]  exp_low_latch_next;
  reg        x_read_next;

  // Minus 128 has no positive partner, so it is held at minus 127
  function [7:0] clamp_wheel;
    input [7:0] v;
    begin
      if (v == 8'h80) begin
        clamp_wheel = `MTRB_WHEEL_MIN;
      end else begin
        clamp_wheel = v;
      end
    end
  endfunction

  function [7:0] clamp_quality;
    input [7:0] v;
    begin
      if (v > `MTRB_QUALITY_MAX) begin
        clamp_quality = `MTRB_QUALITY_MAX;
      end else begin
        clamp_quality = v;
      end
    end
  endfunction

  // True when an accepted read targets the given offset
  function read_hit;
    input       ok;
    input [7:0] addr;
    input [7:0] target;
    begin
      read_hit = ok && (addr == target);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Access qualification

  wire access_ok;
  wire x_low_hit;
  wire exp_high_hit;

  // Reads are ignored while the port is held in USB reset
  assign access_ok    = reg_read && !usb_reset;
  assign x_low_hit    = read_hit(access_ok, reg_addr, `MTRB_OFF_X_LOW);
  assign exp_high_hit = read_hit(access_ok, reg_addr, `MTRB_OFF_EXP_HIGH);

  ////////////////////////////////////////////////////////////////////////
  // Next values

  always @* begin
    motion_x_next      = motion_x_reg;
    motion_y_next      = motion_y_reg;
    wheel_next         = wheel_reg;
    quality_next       = quality_reg;
    exposure_next      = exposure_reg;
    exp_low_latch_next = exp_low_latch_reg;
    x_read_next        = x_read_reg;

    if (motion_load) begin
      motion_x_next = motion_x;
      motion_y_next = motion_y;
    end

    if (wheel_load) begin
      wheel_next = clamp_wheel(wheel_in);
    end

    if (frame_done) begin
      quality_next  = clamp_quality(quality_in);
      exposure_next = exposure_in;
    end

    // USB reset forgets the X-low read, so the read order starts over
    if (usb_reset) begin
      x_read_next = 1'b0;
    end else if (x_low_hit) begin
      x_read_next = 1'b1;
    end

    // High and low byte handed out from one exposure sample
    if (exp_high_hit) begin
      exp_low_latch_next = exposure_reg[7:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // State registers

  always @(posedge sys_clk) begin
    if (!rst_b) begin
      motion_x_reg      <= `MTRB_RST_MOTION;
      motion_y_reg      <= `MTRB_RST_MOTION;
      wheel_reg         <= `MTRB_RST_BYTE;
      quality_reg       <= `MTRB_RST_BYTE;
      exposure_reg      <= `MTRB_RST_EXPOSURE;
      exp_low_latch_reg <= `MTRB_RST_EXP_LOW;
      x_read_reg        <= 1'b0;
    end else begin
      motion_x_reg      <= motion_x_next;
      motion_y_reg      <= motion_y_next;
      wheel_reg         <= wheel_next;
      quality_reg       <= quality_next;
      exposure_reg      <= exposure_next;
      exp_low_latch_reg <= exp_low_latch_next;
      x_read_reg        <= x_read_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read data

  reg [7:0] rdata_next;

  always @* begin
    rdata_next = `MTRB_UNMAPPED_DATA;
    case (reg_addr)
      `MTRB_OFF_BUTTON:   rdata_next = {5'h00, button_clean};
      `MTRB_OFF_X_LOW:    rdata_next = motion_x_reg[7:0];
      `MTRB_OFF_Y_LOW:    rdata_next = x_read_reg ? motion_y_reg[7:0] : 8'h00;
      `MTRB_OFF_XY_HIGH:  rdata_next = x_read_reg ? {motion_x_reg[11:8], motion_y_reg[11:8]} : 8'h00;
      `MTRB_OFF_WHEEL:    rdata_next = wheel_reg;
      `MTRB_OFF_QUALITY:  rdata_next = quality_reg;
      `MTRB_OFF_EXP_HIGH: rdata_next = exposure_reg[15:8];
      `MTRB_OFF_EXP_LOW:  rdata_next = exp_low_latch_reg;
      default:            rdata_next = `MTRB_UNMAPPED_DATA;
    endcase
  end

  always @(posedge sys_clk) begin
    if (!rst_b) begin
      reg_rdata  <= 8'h00;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= access_ok;
      reg_rdata  <= access_ok ? rdata_next : 8'h00;
    end
  end

endmodule
